// ===== rtl/lpf_top.sv
`timescale 1ns/100ps
`include "lpf_regs.svh"

// Operation
// - Message class at low bits 12:9
// - Opcode at 8:5, bit 8 sizes packet
// - Virtual network at 4:3, 1x adaptive
// - Line state at high bits 19:16
// - Remote node split, destination at 17:13
// - Derived settings use low bits 12:0
// - 0x1C00/0x1F80 selects any line data
// - State qualifier picks modified, exclusive, forwarding
// - 0x1C40 completion, 0x1C20 force-acknowledge data
// - 0x1C80/0x1CA0/0x1CC0 select writeback flavours
// - Any, 9-flit and 11-flit data responses
// - Bypass any, 9-flit, 11-flit, interrupt selection
// - Rate code in bits 2:0, reset 011
// - Bit 4 mirrors slow mode, set at reset
// - Base codes 0x04-0x0B buffer events
// - Base codes for power-state cycles
// - Spawn 0x13, cycles 0x14, group zero flits
// - Extended flit groups and filter hit 0x38
// - Extended per-class allocations and occupancy
// - Extended credit return and consumption codes
// - Filter hit adds one per hitting slot
module lpf_top #(
    parameter int NUM_CTR = 4,
    parameter int INC_W   = 8
) (
    // Clock and reset
    input  wire logic                     CLK_IN,
    input  wire logic                     RST_IN,
    // Configuration access
    input  wire logic [11:0]              CFG_ADDR_IN,
    input  wire logic                     CFG_WR_IN,
    input  wire logic                     CFG_RD_IN,
    input  wire logic [31:0]              CFG_WDATA_IN,
    output logic      [31:0]              CFG_RDATA_OUT,
    output logic                          CFG_RVALID_OUT,
    // Rate setting driven from PLL control
    input  wire logic [2:0]               LINK_RATE_IN,
    input  wire logic                     SLOW_MODE_IN,
    // Two packet slots per cycle
    input  wire logic [1:0]               SLOT_VALID_IN,
    input  wire logic [7:0]               SLOT_CLASS_IN,
    input  wire logic [7:0]               SLOT_OPCODE_IN,
    input  wire logic [3:0]               SLOT_VNET_IN,
    input  wire logic [9:0]               SLOT_DNID_IN,
    input  wire logic [9:0]               SLOT_RNID_IN,
    input  wire logic [7:0]               SLOT_STATE_IN,
    // Raw link-layer events
    input  wire logic [5:0]               TX_FLITS_IN,
    input  wire logic [5:0]               RX_FLITS_IN,
    input  wire logic [3:0]               TX_BUF_EVT_IN,
    input  wire logic [2:0]               RX_BUF_EVT_IN,
    input  wire logic [7:0]               RX_OCC_IN,
    input  wire logic [4:0]               POWER_EVT_IN,
    input  wire logic                     SPAWN_IN,
    input  wire logic [5:0]               CLASS_ALLOC_IN,
    input  wire logic [47:0]              CLASS_OCC_IN,
    input  wire logic [7:0]               CREDIT_OCC_IN,
    input  wire logic [2:0]               CREDIT_EVT_IN,
    // Counter event selection
    input  wire logic [NUM_CTR*8-1:0]     EVT_SEL_IN,
    input  wire logic [NUM_CTR-1:0]       EVT_EXT_IN,
    // Results
    output logic      [1:0]               FILTER_HIT_INC_OUT,
    output logic      [NUM_CTR*INC_W-1:0] EVT_INC_OUT
);

    logic [31:0] match_lo_r;
    logic [31:0] match_hi_r;
    logic [31:0] mask_lo_r;
    logic [31:0] mask_hi_r;
    logic [2:0]  rate_r;
    logic        slow_r;
    logic [3:0]  sync1_r;
    logic [3:0]  sync2_r;
    logic [3:0]  sync3_r;
    logic [31:0] rdata_nxt;
    logic [1:0]  slot_hit;
    logic [1:0]  hit_cnt;

    // Address decode
    logic sel_match_lo;
    logic sel_match_hi;
    logic sel_mask_lo;
    logic sel_mask_hi;
    logic sel_rate;
    assign sel_match_lo = (CFG_ADDR_IN == `LPF_OFF_MATCH_LO);
    assign sel_match_hi = (CFG_ADDR_IN == `LPF_OFF_MATCH_HI);
    assign sel_mask_lo  = (CFG_ADDR_IN == `LPF_OFF_MASK_LO);
    assign sel_mask_hi  = (CFG_ADDR_IN == `LPF_OFF_MASK_HI);
    assign sel_rate     = (CFG_ADDR_IN == `LPF_OFF_RATE);

    // Reserved bits are not stored, so a careless write cannot widen the filter
    logic [31:0] wdata_lo;
    logic [31:0] wdata_hi;
    assign wdata_lo = CFG_WDATA_IN & `LPF_LO_IMPL;
    assign wdata_hi = CFG_WDATA_IN & `LPF_HI_IMPL;

    // Write enables; the rate register has none, so writes to it are dropped
    logic we_match_lo;
    logic we_match_hi;
    logic we_mask_lo;
    logic we_mask_hi;
    assign we_match_lo = CFG_WR_IN && sel_match_lo;
    assign we_match_hi = CFG_WR_IN && sel_match_hi;
    assign we_mask_lo  = CFG_WR_IN && sel_mask_lo;
    assign we_mask_hi  = CFG_WR_IN && sel_mask_hi;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            match_lo_r <= `LPF_LO_RESET;
        end else if (we_match_lo) begin
            match_lo_r <= wdata_lo;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            match_hi_r <= `LPF_HI_RESET;
        end else if (we_match_hi) begin
            match_hi_r <= wdata_hi;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            mask_lo_r <= `LPF_LO_RESET;
        end else if (we_mask_lo) begin
            mask_lo_r <= wdata_lo;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            mask_hi_r <= `LPF_HI_RESET;
        end else if (we_mask_hi) begin
            mask_hi_r <= wdata_hi;
        end
    end

    // Rate pins come from PLL control, outside this clock's domain
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sync1_r <= {`LPF_SLOW_RESET, `LPF_RATE_RESET};
            sync2_r <= {`LPF_SLOW_RESET, `LPF_RATE_RESET};
            sync3_r <= {`LPF_SLOW_RESET, `LPF_RATE_RESET};
        end else begin
            sync1_r <= {SLOW_MODE_IN, LINK_RATE_IN};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Take a new setting only once two stages agree, so a skewed change is never seen half-way
    logic rate_stable;
    assign rate_stable = (sync2_r == sync3_r);

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rate_r <= `LPF_RATE_RESET;
            slow_r <= `LPF_SLOW_RESET;
        end else if (rate_stable) begin
            rate_r <= sync3_r[2:0];
            slow_r <= sync3_r[3];
        end
    end

    // Read mux; unmapped addresses read zero, rate register ignores writes
    logic [31:0] rate_word;
    assign rate_word = ({29'h0000_0000, rate_r} << `LPF_RATE_LSB)
                       | ({31'h0000_0000, slow_r} << `LPF_SLOW_POS);

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (sel_match_lo) begin
            rdata_nxt = match_lo_r;
        end else if (sel_match_hi) begin
            rdata_nxt = match_hi_r;
        end else if (sel_mask_lo) begin
            rdata_nxt = mask_lo_r;
        end else if (sel_mask_hi) begin
            rdata_nxt = mask_hi_r;
        end else if (sel_rate) begin
            rdata_nxt = rate_word;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            CFG_RDATA_OUT  <= 32'h0000_0000;
            CFG_RVALID_OUT <= 1'b0;
        end else begin
            CFG_RDATA_OUT  <= CFG_RD_IN ? rdata_nxt : 32'h0000_0000;
            CFG_RVALID_OUT <= CFG_RD_IN;
        end
    end

    // One comparator per slot; the derived selections follow from the masked compare
    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_slot
            lpf_slot_match u_match (
                .valid_in    (SLOT_VALID_IN[s]),
                .class_in    (SLOT_CLASS_IN[s*4 +: 4]),
                .opcode_in   (SLOT_OPCODE_IN[s*4 +: 4]),
                .vnet_in     (SLOT_VNET_IN[s*2 +: 2]),
                .dnid_in     (SLOT_DNID_IN[s*5 +: 5]),
                .rnid_in     (SLOT_RNID_IN[s*5 +: 5]),
                .state_in    (SLOT_STATE_IN[s*4 +: 4]),
                .match_lo_in (match_lo_r),
                .mask_lo_in  (mask_lo_r),
                .match_hi_in (match_hi_r),
                .mask_hi_in  (mask_hi_r),
                .hit_out     (slot_hit[s])
            );
        end
    endgenerate

    assign hit_cnt = {1'b0, slot_hit[0]} + {1'b0, slot_hit[1]};

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            FILTER_HIT_INC_OUT <= 2'h0;
        end else begin
            FILTER_HIT_INC_OUT <= hit_cnt;
        end
    end

    // Event selection per counter; unknown codes add nothing
    genvar c;
    generate
        for (c = 0; c < NUM_CTR; c++) begin : g_ctr
            logic [7:0]       code;
            logic [7:0]       inc_base;
            logic [7:0]       inc_ext;
            logic [INC_W-1:0] inc_nxt;
            assign code = EVT_SEL_IN[c*8 +: 8];

            always_comb begin
                inc_base = 8'h00;
                unique case (code)
                    `LPF_EV_TX_G0:     inc_base = {6'h00, TX_FLITS_IN[1:0]};
                    `LPF_EV_RX_G0:     inc_base = {6'h00, RX_FLITS_IN[1:0]};
                    `LPF_EV_TX_ALLOC:  inc_base = {7'h00, TX_BUF_EVT_IN[0]};
                    `LPF_EV_TX_BYPASS: inc_base = {7'h00, TX_BUF_EVT_IN[1]};
                    `LPF_EV_TX_NE:     inc_base = {7'h00, TX_BUF_EVT_IN[2]};
                    `LPF_EV_TX_OCC:    inc_base = {7'h00, TX_BUF_EVT_IN[3]};
                    `LPF_EV_RX_ALLOC:  inc_base = {7'h00, RX_BUF_EVT_IN[0]};
                    `LPF_EV_RX_BYPASS: inc_base = {7'h00, RX_BUF_EVT_IN[1]};
                    `LPF_EV_RX_NE:     inc_base = {7'h00, RX_BUF_EVT_IN[2]};
                    `LPF_EV_RX_OCC:    inc_base = RX_OCC_IN;
                    `LPF_EV_TX_FULL:   inc_base = {7'h00, POWER_EVT_IN[0]};
                    `LPF_EV_TX_HALF:   inc_base = {7'h00, POWER_EVT_IN[1]};
                    `LPF_EV_RX_FULL:   inc_base = {7'h00, POWER_EVT_IN[2]};
                    `LPF_EV_RX_HALF:   inc_base = {7'h00, POWER_EVT_IN[3]};
                    `LPF_EV_SHUTDOWN:  inc_base = {7'h00, POWER_EVT_IN[4]};
                    `LPF_EV_SPAWN:     inc_base = {7'h00, SPAWN_IN};
                    `LPF_EV_CYCLES:    inc_base = 8'h01;
                    default:           inc_base = 8'h00;
                endcase
            end

            always_comb begin
                inc_ext = 8'h00;
                if (code >= `LPF_EX_ALLOC_FIRST && code <= `LPF_EX_ALLOC_LAST) begin
                    inc_ext = {7'h00, CLASS_ALLOC_IN[3'(code - `LPF_EX_ALLOC_FIRST)]};
                end else if (code >= `LPF_EX_OCC_FIRST && code <= `LPF_EX_OCC_LAST) begin
                    inc_ext = CLASS_OCC_IN[6'(code - `LPF_EX_OCC_FIRST) * 8 +: 8];
                end else begin
                    unique case (code)
                        `LPF_EX_TX_G1:      inc_ext = {6'h00, TX_FLITS_IN[3:2]};
                        `LPF_EX_TX_G2:      inc_ext = {6'h00, TX_FLITS_IN[5:4]};
                        `LPF_EX_RX_G1:      inc_ext = {6'h00, RX_FLITS_IN[3:2]};
                        `LPF_EX_RX_G2:      inc_ext = {6'h00, RX_FLITS_IN[5:4]};
                        `LPF_EX_CRED_OCC:   inc_ext = CREDIT_OCC_IN;
                        `LPF_EX_CRED_RET:   inc_ext = {7'h00, CREDIT_EVT_IN[0]};
                        `LPF_EX_CRED_VNA:   inc_ext = {7'h00, CREDIT_EVT_IN[1]};
                        `LPF_EX_CRED_VN0:   inc_ext = {7'h00, CREDIT_EVT_IN[2]};
                        `LPF_EX_FILTER_HIT: inc_ext = {6'h00, hit_cnt};
                        default:            inc_ext = 8'h00;
                    endcase
                end
            end

            // Extension bit picks the second code group
            assign inc_nxt = INC_W'(EVT_EXT_IN[c] ? inc_ext : inc_base);

            always_ff @(posedge CLK_IN or posedge RST_IN) begin
                if (RST_IN) begin
                    EVT_INC_OUT[c*INC_W +: INC_W] <= '0;
                end else begin
                    EVT_INC_OUT[c*INC_W +: INC_W] <= inc_nxt;
                end
            end
        end
    endgenerate

endmodule // lpf_top

// ===== rtl/lpf_regs.svh
`ifndef LPF_REGS_SVH
`define LPF_REGS_SVH

// Register byte offsets
`define LPF_OFF_MATCH_LO    12'h228
`define LPF_OFF_MATCH_HI    12'h22C
`define LPF_OFF_MASK_LO     12'h238
`define LPF_OFF_MASK_HI     12'h23C
`define LPF_OFF_RATE        12'h0D4

// Implemented bits of the match/mask pairs
`define LPF_LO_IMPL         32'h8003_FFF8
`define LPF_HI_IMPL         32'h000F_000F
`define LPF_LO_RESET        32'h0000_0000
`define LPF_HI_RESET        32'h0000_0000

// Low word field positions
`define LPF_RNID_TOP_POS    31
`define LPF_DNID_LSB        13
`define LPF_CLASS_LSB       9
`define LPF_OPC_LSB         5
`define LPF_VNET_LSB        3
`define LPF_DERIVED_MSB     12

// High word field positions
`define LPF_STATE_LSB       16
`define LPF_STATE_FIELD     32'h000F_0000
`define LPF_RNID_LOW_LSB    0
`define LPF_STATE_OPC_MAX   4'h2

// Rate status layout and reset
`define LPF_RATE_LSB        0
`define LPF_SLOW_POS        4
`define LPF_RATE_RESET      3'h3
`define LPF_SLOW_RESET      1'b1

// Event codes, extension clear
`define LPF_EV_TX_G0        8'h00
`define LPF_EV_RX_G0        8'h01
`define LPF_EV_TX_ALLOC     8'h04
`define LPF_EV_TX_BYPASS    8'h05
`define LPF_EV_TX_NE        8'h06
`define LPF_EV_TX_OCC       8'h07
`define LPF_EV_RX_ALLOC     8'h08
`define LPF_EV_RX_BYPASS    8'h09
`define LPF_EV_RX_NE        8'h0A
`define LPF_EV_RX_OCC       8'h0B
`define LPF_EV_TX_FULL      8'h0C
`define LPF_EV_TX_HALF      8'h0D
`define LPF_EV_RX_FULL      8'h0F
`define LPF_EV_RX_HALF      8'h10
`define LPF_EV_SHUTDOWN     8'h12
`define LPF_EV_SPAWN        8'h13
`define LPF_EV_CYCLES       8'h14

// Event codes, extension set
`define LPF_EX_TX_G1        8'h00
`define LPF_EX_TX_G2        8'h01
`define LPF_EX_RX_G1        8'h02
`define LPF_EX_RX_G2        8'h03
`define LPF_EX_ALLOC_FIRST  8'h09
`define LPF_EX_ALLOC_LAST   8'h0E
`define LPF_EX_OCC_FIRST    8'h15
`define LPF_EX_OCC_LAST     8'h1A
`define LPF_EX_CRED_OCC     8'h1B
`define LPF_EX_CRED_RET     8'h1C
`define LPF_EX_CRED_VNA     8'h1D
`define LPF_EX_CRED_VN0     8'h1E
`define LPF_EX_FILTER_HIT   8'h38

`endif

// ===== rtl/lpf_pkg.sv
package lpf_pkg;

    // Message class encodings
    typedef enum logic [3:0] {
        LPF_COHERENCE_REQUEST_CLASS  = 4'h0,
        LPF_COHERENCE_RESPONSE_CLASS = 4'h1,
        LPF_NONDATA_RESPONSE_CLASS   = 4'h2,
        LPF_PROBE_CLASS              = 4'h3,
        LPF_NONCOHERENT_STD_CLASS    = 4'h4,
        LPF_NONCOHERENT_BYPASS_CLASS = 4'hC,
        LPF_DATA_RESPONSE_CLASS      = 4'hE
    } lpf_msg_class_t;

    // Virtual network encodings, 1x is adaptive
    typedef enum logic [1:0] {
        LPF_VNET_ZERO     = 2'h0,
        LPF_VNET_ONE      = 2'h1,
        LPF_ADAPTIVE_VNET = 2'h2
    } lpf_vnet_t;

    // One-hot response line state
    typedef enum logic [3:0] {
        LPF_STATE_INVALID   = 4'h0,
        LPF_STATE_FORWARD   = 4'h1,
        LPF_STATE_SHARED    = 4'h2,
        LPF_STATE_EXCLUSIVE = 4'h4,
        LPF_STATE_MODIFIED  = 4'h8
    } lpf_line_state_t;

endpackage

// ===== rtl/lpf_slot_match.sv
`timescale 1ns/100ps
`include "lpf_regs.svh"

module lpf_slot_match (
    // Packet slot
    input  wire logic        valid_in,
    input  wire logic [3:0]  class_in,
    input  wire logic [3:0]  opcode_in,
    input  wire logic [1:0]  vnet_in,
    input  wire logic [4:0]  dnid_in,
    input  wire logic [4:0]  rnid_in,
    input  wire logic [3:0]  state_in,
    // Filter setting
    input  wire logic [31:0] match_lo_in,
    input  wire logic [31:0] mask_lo_in,
    input  wire logic [31:0] match_hi_in,
    input  wire logic [31:0] mask_hi_in,
    // Result
    output logic             hit_out
);

    logic [31:0] pkt_lo;
    logic [31:0] pkt_hi;
    logic        state_valid;
    logic [31:0] mask_hi_eff;
    logic        lo_ok;
    logic        hi_ok;

    // Remote node split over both words, destination in the low word
    assign pkt_lo = {rnid_in[4], 13'h0000, dnid_in, class_in, opcode_in, vnet_in, 3'h0};
    assign pkt_hi = {12'h000, state_in, 12'h000, rnid_in[3:0]};

    // Line state only means something on data responses with opcode 0..2
    assign state_valid = (class_in == lpf_pkg::LPF_DATA_RESPONSE_CLASS)
                         && (opcode_in <= `LPF_STATE_OPC_MAX);
    assign mask_hi_eff = state_valid ? mask_hi_in : (mask_hi_in & ~`LPF_STATE_FIELD);

    assign lo_ok   = (((pkt_lo ^ match_lo_in) & mask_lo_in) == 32'h0000_0000);
    assign hi_ok   = (((pkt_hi ^ match_hi_in) & mask_hi_eff) == 32'h0000_0000);
    assign hit_out = valid_in && lo_ok && hi_ok;

endmodule // lpf_slot_match

// ===== bench/lpf_top_checker.sv
`timescale 1ns/100ps
module lpf_top_checker #(
    parameter int NUM_CTR = 4,
    parameter int INC_W   = 8
) (
    // Clock and reset
    input wire logic                     CLK_IN,
    input wire logic                     RST_IN,
    // Configuration access
    input wire logic [11:0]              CFG_ADDR_IN,
    input wire logic                     CFG_RD_IN,
    input wire logic [31:0]              CFG_RDATA_OUT,
    input wire logic                     CFG_RVALID_OUT,
    // Packet slots and raw events
    input wire logic [1:0]               SLOT_VALID_IN,
    input wire logic                     SPAWN_IN,
    // Event selection and results
    input wire logic [NUM_CTR*8-1:0]     EVT_SEL_IN,
    input wire logic [NUM_CTR-1:0]       EVT_EXT_IN,
    input wire logic [1:0]               FILTER_HIT_INC_OUT,
    input wire logic [NUM_CTR*INC_W-1:0] EVT_INC_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    // Read request and its one-cycle answer
    sequence s_rd_req;
        CFG_RD_IN;
    endsequence
    sequence s_rd_ans;
        CFG_RVALID_OUT;
    endsequence
    sequence s_rate_req;
        CFG_RD_IN && CFG_ADDR_IN == 12'h0D4;
    endsequence

    a_rd_answer: assert property (s_rd_req |=> s_rd_ans)
        else $error("read strobe not answered");
    a_idle_quiet: assert property (!CFG_RD_IN |=> !CFG_RVALID_OUT && CFG_RDATA_OUT == 32'h0000_0000)
        else $error("read data without a read");
    a_rate_rsvd: assert property (s_rate_req |=> CFG_RDATA_OUT[31:5] == 27'h000_0000 && !CFG_RDATA_OUT[3])
        else $error("rate status reserved bits set");
    a_hit_none: assert property (SLOT_VALID_IN == 2'h0 |=> FILTER_HIT_INC_OUT == 2'h0)
        else $error("hit without valid slot");
    a_hit_bound: assert property (1'b1 |=>
        FILTER_HIT_INC_OUT <= {1'b0, $past(SLOT_VALID_IN[0])} + {1'b0, $past(SLOT_VALID_IN[1])})
        else $error("more hits than valid slots");
    a_cycle_tick: assert property (EVT_SEL_IN[7:0] == 8'h14 && !EVT_EXT_IN[0] |=>
        EVT_INC_OUT[INC_W-1:0] == INC_W'(1))
        else $error("cycle event not one");
    a_spawn_pass: assert property (EVT_SEL_IN[7:0] == 8'h13 && !EVT_EXT_IN[0] |=>
        EVT_INC_OUT[INC_W-1:0] == INC_W'($past(SPAWN_IN)))
        else $error("spawn event mismatch");
    a_filter_event: assert property (EVT_SEL_IN[7:0] == 8'h38 && EVT_EXT_IN[0] |=>
        EVT_INC_OUT[INC_W-1:0] == INC_W'(FILTER_HIT_INC_OUT))
        else $error("filter event differs from hits");
    a_undef_zero: assert property (EVT_SEL_IN[7:0] == 8'h11 && !EVT_EXT_IN[0] |=>
        EVT_INC_OUT[INC_W-1:0] == INC_W'(0))
        else $error("undefined code counts");
endmodule // lpf_top_checker

bind lpf_top lpf_top_checker #(.NUM_CTR(NUM_CTR), .INC_W(INC_W)) i_lpf_top_checker (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .CFG_ADDR_IN(CFG_ADDR_IN), .CFG_RD_IN(CFG_RD_IN),
    .CFG_RDATA_OUT(CFG_RDATA_OUT), .CFG_RVALID_OUT(CFG_RVALID_OUT), .SLOT_VALID_IN(SLOT_VALID_IN),
    .SPAWN_IN(SPAWN_IN), .EVT_SEL_IN(EVT_SEL_IN), .EVT_EXT_IN(EVT_EXT_IN),
    .FILTER_HIT_INC_OUT(FILTER_HIT_INC_OUT), .EVT_INC_OUT(EVT_INC_OUT));

// ===== bench/lpf_top_bench.sv
`timescale 1ns/100ps
module lpf_top_bench;
    logic        clk, rst, wr, rd, rv, slow, spn;
    logic [11:0] addr;
    logic [31:0] wd, rdat, esel, einc;
    logic [2:0]  rate, rxb, cre;
    logic [1:0]  sv, hit;
    logic [7:0]  scl, sop, sst, rxo, cro;
    logic [3:0]  svn, txb, eext;
    logic [9:0]  sdn, srn;
    logic [5:0]  txf, rxf, cal;
    logic [4:0]  pwr;
    logic [47:0] cocc;
    int          err_count;
    int          n_tests;
    // Entries are {code, expected increment}
    localparam logic [15:0] E0 [18] = '{16'h0002, 16'h0101, 16'h0400, 16'h0501, 16'h0600, 16'h0701, 16'h0801,
        16'h0900, 16'h0A01, 16'h0B80, 16'h0C01, 16'h0D00, 16'h0F01, 16'h1000, 16'h1201, 16'h1301, 16'h1401, 16'h1100};
    localparam logic [15:0] E1 [21] = '{16'h0001, 16'h0102, 16'h0202, 16'h0301, 16'h0901, 16'h0A00, 16'h0B01,
        16'h0C00, 16'h0D00, 16'h0E01, 16'h150A, 16'h1614, 16'h171E, 16'h1828, 16'h1932, 16'h1A3C, 16'h1B4D,
        16'h1C00, 16'h1D01, 16'h1E01, 16'h3800};
    localparam logic [3:0] CLS [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hC, 4'hE};

    always #4 clk = ~clk;

    lpf_top i_lpf_top (.CLK_IN(clk), .RST_IN(rst), .CFG_ADDR_IN(addr), .CFG_WR_IN(wr), .CFG_RD_IN(rd),
        .CFG_WDATA_IN(wd), .CFG_RDATA_OUT(rdat), .CFG_RVALID_OUT(rv), .LINK_RATE_IN(rate), .SLOW_MODE_IN(slow),
        .SLOT_VALID_IN(sv), .SLOT_CLASS_IN(scl), .SLOT_OPCODE_IN(sop), .SLOT_VNET_IN(svn), .SLOT_DNID_IN(sdn),
        .SLOT_RNID_IN(srn), .SLOT_STATE_IN(sst), .TX_FLITS_IN(txf), .RX_FLITS_IN(rxf), .TX_BUF_EVT_IN(txb),
        .RX_BUF_EVT_IN(rxb), .RX_OCC_IN(rxo), .POWER_EVT_IN(pwr), .SPAWN_IN(spn), .CLASS_ALLOC_IN(cal),
        .CLASS_OCC_IN(cocc), .CREDIT_OCC_IN(cro), .CREDIT_EVT_IN(cre), .EVT_SEL_IN(esel), .EVT_EXT_IN(eext),
        .FILTER_HIT_INC_OUT(hit), .EVT_INC_OUT(einc));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cfg_wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // Answer stands one cycle only, so it is sampled at the first falling edge
    task automatic cfg_rd(input logic [11:0] a, input logic [31:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk({31'h0000_0000, rv}, 32'h0000_0001, "read valid");
        chk(rdat, exp, "read data");
    endtask

    function automatic logic [23:0] pk(input logic [3:0] c, o, input logic [1:0] v, input logic [4:0] d, r,
                                       input logic [3:0] s);
        return {c, o, v, d, r, s};
    endfunction

    task automatic flt(input logic [31:0] mlo, klo, mhi, khi, input logic [23:0] p0, p1, input logic [1:0] v, e);
        cfg_wr(12'h228, mlo);
        cfg_wr(12'h238, klo);
        cfg_wr(12'h22C, mhi);
        cfg_wr(12'h23C, khi);
        @(negedge clk);
        esel = {4{8'h38}};
        eext = 4'hF;
        sv = v;
        {scl[3:0], sop[3:0], svn[1:0], sdn[4:0], srn[4:0], sst[3:0]} = p0;
        {scl[7:4], sop[7:4], svn[3:2], sdn[9:5], srn[9:5], sst[7:4]} = p1;
        @(negedge clk);
        sv = 2'h0;
        chk({30'h0000_0000, hit}, {30'h0000_0000, e}, "filter hits");
        chk(einc, {4{6'h00, e}}, "filter event");
    endtask

    task automatic ev(input logic x, input logic [15:0] t);
        @(negedge clk);
        esel = {4{t[15:8]}};
        eext = {4{x}};
        @(negedge clk);
        chk(einc, {4{t[7:0]}}, "event increment");
    endtask

    initial begin
        {clk, wr, rd, sv, scl, sop, svn, sdn, srn, sst, esel, eext, addr, wd} = '0;
        {rst, rate, slow, spn} = {1'b1, 3'h3, 1'b1, 1'b1};
        {txf, rxf, txb, rxb, rxo, pwr} = {6'h26, 6'h19, 4'hA, 3'h5, 8'h80, 5'h15};
        {cal, cocc, cro, cre} = {6'h25, 48'h3C32_281E_140A, 8'h4D, 3'h6};
        err_count = 0;
        n_tests = 0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) cfg_rd(12'h228 + 12'(i * 4) + 12'(i / 2 * 8), 32'h0000_0000);
        cfg_rd(12'h0D4, 32'h0000_0013);
        $display("Reset values done");
        for (int i = 0; i < 4; i++) cfg_wr(12'h228 + 12'(i * 4) + 12'(i / 2 * 8), 32'hFFFF_FFFF);
        cfg_wr(12'h0D4, 32'hFFFF_FFFF);
        cfg_wr(12'h100, 32'hFFFF_FFFF);
        cfg_rd(12'h228, 32'h8003_FFF8);
        cfg_rd(12'h22C, 32'h000F_000F);
        cfg_rd(12'h238, 32'h8003_FFF8);
        cfg_rd(12'h23C, 32'h000F_000F);
        cfg_rd(12'h0D4, 32'h0000_0013);
        cfg_rd(12'h100, 32'h0000_0000);
        for (int r = 2; r < 8; r++) begin
            rate = 3'(r);
            slow = (r == 3);
            repeat (4) @(negedge clk);
            cfg_rd(12'h0D4, {27'h000_0000, slow, 1'b0, rate});
        end
        $display("Registers done");
        foreach (E0[i]) ev(1'b0, E0[i]);
        foreach (E1[i]) ev(1'b1, E1[i]);
        $display("Event codes done");
        flt(0, 0, 0, 0, pk(4'h3, 4'h1, 2'h0, 5'h01, 5'h02, 4'h0),
            pk(4'h4, 4'h2, 2'h1, 5'h03, 5'h04, 4'h1), 2'h3, 2'h2);
        flt(0, 0, 0, 0, pk(4'h3, 4'h1, 2'h0, 5'h01, 5'h02, 4'h0),
            pk(4'h4, 4'h2, 2'h1, 5'h03, 5'h04, 4'h1), 2'h0, 2'h0);
        flt(32'h1C00, 32'h1E00, 0, 0, pk(4'hE, 4'h3, 0, 0, 0, 0), pk(4'hE, 4'h9, 0, 0, 0, 0), 2'h3, 2'h2);
        flt(32'h1C00, 32'h1F00, 0, 0, pk(4'hE, 4'h0, 0, 0, 0, 0), pk(4'hE, 4'h8, 0, 0, 0, 0), 2'h3, 2'h1);
        flt(32'h1D00, 32'h1F00, 0, 0, pk(4'hE, 4'h9, 0, 0, 0, 0), pk(4'hE, 4'hA, 0, 0, 0, 0), 2'h3, 2'h2);
        flt(32'h1C00, 32'h1F80, 0, 0, pk(4'hE, 4'h3, 0, 0, 0, 0), pk(4'hE, 4'h4, 0, 0, 0, 0), 2'h3, 2'h1);
        flt(32'h1C00, 32'h1FE0, 32'h8_0000, 32'hF_0000, pk(4'hE, 0, 0, 0, 0, 4'h8),
            pk(4'hE, 0, 0, 0, 0, 4'h4), 2'h3, 2'h1);
        flt(32'h1C40, 32'h1FE0, 32'h4_0000, 32'hF_0000, pk(4'hE, 2, 0, 0, 0, 4'h4),
            pk(4'hE, 2, 0, 0, 0, 4'h1), 2'h3, 2'h1);
        flt(32'h1C20, 32'h1FE0, 32'h1_0000, 32'hF_0000, pk(4'hE, 1, 0, 0, 0, 4'h1),
            pk(4'hE, 1, 2, 0, 0, 4'h1), 2'h3, 2'h2);
        flt(32'h1CC0, 32'h1FE0, 32'h8_0000, 32'hF_0000, pk(4'hE, 6, 0, 0, 0, 4'h0),
            pk(4'hE, 6, 0, 0, 0, 4'h8), 2'h3, 2'h2);
        flt(32'h1C80, 32'h1FE0, 0, 0, pk(4'hE, 4'h4, 0, 0, 0, 0), pk(4'hE, 4'h5, 0, 0, 0, 0), 2'h3, 2'h1);
        flt(32'h1CA0, 32'h1FE0, 0, 0, pk(4'hE, 4'h5, 0, 0, 0, 0), pk(4'hE, 4'h4, 0, 0, 0, 0), 2'h3, 2'h1);
        flt(32'h1800, 32'h1E00, 0, 0, pk(4'hC, 4'h0, 0, 0, 0, 0), pk(4'hC, 4'h9, 0, 0, 0, 0), 2'h3, 2'h2);
        flt(32'h1800, 32'h1F00, 0, 0, pk(4'hC, 4'h7, 0, 0, 0, 0), pk(4'hC, 4'h8, 0, 0, 0, 0), 2'h3, 2'h1);
        flt(32'h1900, 32'h1F00, 0, 0, pk(4'hC, 4'h8, 0, 0, 0, 0), pk(4'hC, 4'hB, 0, 0, 0, 0), 2'h3, 2'h2);
        flt(32'h1900, 32'h1F80, 0, 0, pk(4'hC, 4'h9, 0, 0, 0, 0), pk(4'hC, 4'hC, 0, 0, 0, 0), 2'h3, 2'h1);
        flt(32'h0010, 32'h0010, 0, 0, pk(4'h0, 4'h0, 2'h3, 0, 0, 0), pk(4'h0, 4'h0, 2'h1, 0, 0, 0), 2'h3, 2'h1);
        flt(32'h8002_A000, 32'h8003_E000, 32'hA, 32'hF, pk(0, 0, 0, 5'h15, 5'h1A, 0),
            pk(0, 0, 0, 5'h15, 5'h0A, 0), 2'h3, 2'h1);
        foreach (CLS[i]) flt({19'h0_0000, CLS[i], 9'h000}, 32'h1E00, 0, 0, pk(CLS[i], 0, 0, 0, 0, 0),
            pk(CLS[i] ^ 4'h1, 0, 0, 0, 0, 0), 2'h3, 2'h1);
        $display("Filter cases done");
        end_of_test();
    end

    // Watchdog: a hang counts as a mismatch
    initial begin
        #400000;
        err_count++;
        end_of_test();
    end
endmodule // lpf_top_bench
